// file: hw/pmc_pkg.sv
// Purpose: Shared constants and types of the power mode controller.
// Assumes: 32-bit APB register bus, one word per register.
// Notes:   Offsets are byte addresses.
package pmc_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFF_PWR_FIRST  = 8'h00;
   localparam logic [7:0] OFF_PWR_SECOND = 8'h04;
   localparam logic [7:0] OFF_REG_CTRL   = 8'h08;
   localparam logic [7:0] OFF_CLK_CTRL   = 8'h0C;
   localparam logic [7:0] OFF_PCLK_CTRL  = 8'h10;
   localparam logic [7:0] OFF_STATUS     = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT   = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK   = 8'h1C;
   localparam logic [7:0] OFF_RETAIN     = 8'h20;

   // Field positions.
   localparam int BIT_CORE_HALT  = 0;
   localparam int BIT_STOP       = 1;
   localparam int BIT_SUSPEND    = 0;
   localparam int BIT_SNOOZE     = 1;
   localparam int BIT_DEEP_SEL   = 0;
   localparam int BIT_TMR3       = 3;
   localparam int BIT_TMR4       = 4;
   localparam int BIT_T3_LFO     = 8;
   localparam int BIT_T4_LFO     = 9;
   localparam int BIT_EV_IDLE    = 0;
   localparam int BIT_EV_SLEEP   = 1;
   localparam int BIT_EV_CLKERR  = 2;
   localparam int IRQ_W          = 3;

   // Wake source positions.
   localparam int WK_TMR4 = 0;
   localparam int WK_SPI  = 1;
   localparam int WK_I2C  = 2;
   localparam int WK_PMAT = 3;
   localparam int WK_CLU  = 4;
   localparam int WK_N    = 5;

   // Reset values: system clock from the 24.5 MHz oscillator, divided by 8.
   localparam logic [1:0] CLK_SRC_24M5  = 2'h0;
   localparam logic [1:0] CLK_SRC_49M   = 2'h1;
   localparam logic [1:0] CLK_SRC_LFO   = 2'h2;
   localparam logic [2:0] CLK_DIV_RESET = 3'h3;
   localparam logic [1:0] CLK_SRC_RESET = CLK_SRC_24M5;

   typedef enum {
      ST_NORMAL, ST_IDLE, ST_SUSPEND, ST_SNOOZE, ST_WAKE, ST_STOP,
      ST_SHUTDOWN
   } pmc_state_t;

   // Power and clock controls driven to the rest of the chip.
   typedef struct packed {
      logic       core_clk_en;
      logic       periph_run;
      logic       osc_24m5_en;
      logic       osc_49m_en;
      logic       low_freq_osc_en;
      logic       reg_low_bias;
      logic       power_nets_off;
      logic       pin_hold;
   } pmc_pwr_t;

   // Running state after reset: core, peripherals and both live oscillators.
   localparam pmc_pwr_t PWR_RESET = 8'hE8;

   typedef struct packed {
      logic [1:0] src;
      logic [2:0] div;
   } pmc_clk_t;

endpackage : pmc_pkg

// file: hw/pmc_top.sv
// Purpose: Power mode controller: normal, idle, suspend, snooze, stop
//          and shutdown sequencing with APB registers and an interrupt.
// Assumes: All inputs synchronous to pclk; pclk stays alive in the low
//          power states (fed from the low-frequency oscillator).
// Notes:   One mode request is served at a time; stop outranks snooze,
//          snooze outranks suspend, suspend outranks idle.
// Notes on behaviour
// RULE_01 - Normal state keeps core and all peripheral clocks running; the code clocks only the peripherals enabled in pclk_ctrl.
// RULE_02 - Core-halt bit halts core only; any interrupt wakes it.
// RULE_03 - Firmware selects 24.5 MHz oscillator before requesting suspend.
// RULE_04 - Suspend stops core, peripheral clocks and both fast oscillators; normal bias.
// RULE_05 - Snooze stops the same clocks and oscillators; regulator low bias.
// RULE_06 - Firmware selects 24.5 MHz oscillator before requesting snooze.
// RULE_07 - Timers 3 and 4 may run from low-frequency oscillator when asleep.
// RULE_08 - Suspend and snooze end on the six listed wake events.
// RULE_09 - Firmware clears deep select, then sets stop, to enter stop.
// RULE_10 - Stop powers nets down, pins hold, any reset source exits.
// RULE_11 - Firmware sets deep select, then sets stop, to enter shutdown.
// RULE_12 - Shutdown exits only on reset pin or power-on reset.
// RULE_13 - After reset system clock is 24.5 MHz oscillator divided by eight.
// RULE_14 - Unused digital peripherals have their clocks gated off.
// RULE_15 - Pin configuration is retained through most resets when enabled.
// RULE_16 - Waking clears the mode request bit that caused entry.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module pmc_top
#(
   parameter int PERIPH_N = 8
)
(
   // APB slave.
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic [31:0]               prdata,
   // Wake and reset sources.
   input  wire logic                 core_irq,
   input  wire logic [4:0]           wake_src,
   input  wire logic                 cmp0_level,
   input  wire logic                 osc_24m5_ready,
   input  wire logic                 reset_pin_n,
   input  wire logic                 por_req,
   input  wire logic                 other_reset_req,
   // Power and clock controls.
   output pmc_pkg::pmc_pwr_t         pwr,
   output pmc_pkg::pmc_clk_t         system_clock,
   output logic [PERIPH_N-1:0]       periph_clk_en,
   output logic                      reset_req,
   output logic                      irq
);

   localparam int IW = pmc_pkg::IRQ_W;

   // Enables above bit 7 would collide with the timer slow-clock selects.
   if (PERIPH_N < 5 || PERIPH_N > pmc_pkg::BIT_T3_LFO)
      $error("PERIPH_N must lie between 5 and 8");

   pmc_pkg::pmc_state_t state, next_state;
   logic [1:0]          power_control_first, next_power_control_first;
   logic [1:0]          power_control_second, next_power_control_second;
   logic                deep_power_down_select, next_deep_power_down_select;
   pmc_pkg::pmc_clk_t   next_system_clock;
   logic [15:0]         pclk_ctrl, next_pclk_ctrl;
   logic [IW-1:0]       irq_stat, next_irq_stat;
   logic [IW-1:0]       irq_mask, next_irq_mask;
   logic                retain_en, next_retain_en;
   logic                cmp0_prev;
   logic [31:0]         next_prdata;
   pmc_pkg::pmc_pwr_t   next_pwr;
   logic [PERIPH_N-1:0] next_periph_clk_en;

   logic          wr_en, rd_setup, mapped;
   logic          wake_any, reset_any, sleep_req;
   logic [IW-1:0] ev_set;

   // The registers fill every word from the first offset to the last.
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a <= pmc_pkg::OFF_RETAIN) && (a[1:0] == 2'h0);
   endfunction : is_mapped

   function automatic logic [3:0] state_code(input pmc_pkg::pmc_state_t s);
      unique case (s)
         pmc_pkg::ST_NORMAL:   state_code = 4'h0;
         pmc_pkg::ST_IDLE:     state_code = 4'h1;
         pmc_pkg::ST_SUSPEND:  state_code = 4'h2;
         pmc_pkg::ST_SNOOZE:   state_code = 4'h3;
         pmc_pkg::ST_WAKE:     state_code = 4'h4;
         pmc_pkg::ST_STOP:     state_code = 4'h5;
         pmc_pkg::ST_SHUTDOWN: state_code = 4'h6;
      endcase
   endfunction : state_code

   // The slave never inserts wait states: read data is captured in the
   // setup cycle so that prdata comes from a flip-flop.
   assign pready   = 1'b1;
   assign mapped   = is_mapped(paddr);
   assign pslverr  = psel & penable & ~mapped;
   assign wr_en    = psel & penable & pwrite & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign irq      = |(irq_stat & irq_mask);

   // Comparator 0 counts only on its rising edge.
   assign wake_any = |wake_src | (cmp0_level & ~cmp0_prev); // see RULE_08

   // Shutdown listens to the reset pin and power-on reset alone.
   assign reset_any = ~reset_pin_n | por_req | // see RULE_10, RULE_12
                      (other_reset_req & (state != pmc_pkg::ST_SHUTDOWN));
   assign reset_req = reset_any;

   assign sleep_req = power_control_second[pmc_pkg::BIT_SUSPEND] |
                      power_control_second[pmc_pkg::BIT_SNOOZE];

   always_comb
   begin
      next_state                  = state;
      next_power_control_first    = power_control_first;
      next_power_control_second   = power_control_second;
      next_deep_power_down_select = deep_power_down_select;
      next_system_clock           = system_clock;
      next_pclk_ctrl              = pclk_ctrl;
      next_irq_mask               = irq_mask;
      next_retain_en              = retain_en;
      next_prdata                 = prdata;
      ev_set                      = '0;

      // Register writes.
      if (wr_en)
      begin
         unique case (paddr)
            pmc_pkg::OFF_PWR_FIRST:
               next_power_control_first = pwdata[1:0];
            pmc_pkg::OFF_PWR_SECOND:
               next_power_control_second = pwdata[1:0];
            pmc_pkg::OFF_REG_CTRL:
               next_deep_power_down_select = pwdata[pmc_pkg::BIT_DEEP_SEL];
            pmc_pkg::OFF_CLK_CTRL:
            begin
               next_system_clock.src = pwdata[1:0];
               next_system_clock.div = pwdata[4:2];
            end
            pmc_pkg::OFF_PCLK_CTRL:
               next_pclk_ctrl = pwdata[15:0];
            pmc_pkg::OFF_IRQ_MASK:
               next_irq_mask = pwdata[IW-1:0];
            pmc_pkg::OFF_RETAIN:
               next_retain_en = pwdata[0];
            default:
               next_retain_en = retain_en;
         endcase
      end

      // Mode sequencing.
      unique case (state)
         pmc_pkg::ST_NORMAL:
         begin
            if (power_control_first[pmc_pkg::BIT_STOP])
            begin
               if (deep_power_down_select)
                  next_state = pmc_pkg::ST_SHUTDOWN; // see RULE_11
               else
                  next_state = pmc_pkg::ST_STOP; // see RULE_09
            end
            else if (sleep_req &&
                     system_clock.src != pmc_pkg::CLK_SRC_24M5)
            begin
               // Entry from a clock other than 24.5 MHz is refused and
               // flagged, since the wake path restarts only that one.
               next_power_control_second = '0; // see RULE_03, RULE_06
               ev_set[pmc_pkg::BIT_EV_CLKERR] = 1'b1;
            end
            else if (power_control_second[pmc_pkg::BIT_SNOOZE])
               next_state = pmc_pkg::ST_SNOOZE; // see RULE_06
            else if (power_control_second[pmc_pkg::BIT_SUSPEND])
               next_state = pmc_pkg::ST_SUSPEND; // see RULE_03
            else if (power_control_first[pmc_pkg::BIT_CORE_HALT])
               next_state = pmc_pkg::ST_IDLE; // see RULE_02
         end
         pmc_pkg::ST_IDLE:
            if (core_irq)
            begin
               next_state = pmc_pkg::ST_NORMAL; // see RULE_02
               next_power_control_first[pmc_pkg::BIT_CORE_HALT] = 1'b0; // see RULE_16
               ev_set[pmc_pkg::BIT_EV_IDLE] = 1'b1;
            end
         pmc_pkg::ST_SUSPEND, pmc_pkg::ST_SNOOZE:
            if (wake_any)
            begin
               next_state = pmc_pkg::ST_WAKE; // see RULE_08
               next_power_control_second = '0; // see RULE_16
            end
         pmc_pkg::ST_WAKE:
            // The core is held until the restarted oscillator is stable.
            if (osc_24m5_ready)
            begin
               next_state = pmc_pkg::ST_NORMAL;
               ev_set[pmc_pkg::BIT_EV_SLEEP] = 1'b1;
            end
         pmc_pkg::ST_STOP, pmc_pkg::ST_SHUTDOWN:
            next_state = state;
      endcase

      // An accepted reset returns everything to its reset value, except
      // that the retention enable survives a reset other than power-on.
      if (reset_any)
      begin
         next_state                  = pmc_pkg::ST_NORMAL; // see RULE_10, RULE_12
         next_power_control_first    = '0;
         next_power_control_second   = '0;
         next_deep_power_down_select = 1'b0;
         next_system_clock.src       = pmc_pkg::CLK_SRC_RESET; // see RULE_13
         next_system_clock.div       = pmc_pkg::CLK_DIV_RESET;
         next_pclk_ctrl              = '0;
         next_irq_mask               = '0;
         next_retain_en              = retain_en & ~por_req; // see RULE_15
         ev_set                      = '0;
      end

      // Set wins over a write-one-to-clear in the same cycle.
      next_irq_stat = irq_stat;
      if (wr_en && paddr == pmc_pkg::OFF_IRQ_STAT)
         next_irq_stat = irq_stat & ~pwdata[IW-1:0];
      next_irq_stat = next_irq_stat | ev_set;
      if (reset_any)
         next_irq_stat = '0;

      // Read data is sampled in the setup cycle.
      if (rd_setup)
      begin
         unique case (paddr)
            pmc_pkg::OFF_PWR_FIRST:
               next_prdata = {30'h0, power_control_first};
            pmc_pkg::OFF_PWR_SECOND:
               next_prdata = {30'h0, power_control_second};
            pmc_pkg::OFF_REG_CTRL:
               next_prdata = {31'h0, deep_power_down_select};
            pmc_pkg::OFF_CLK_CTRL:
               next_prdata = {27'h0, system_clock.div, system_clock.src};
            pmc_pkg::OFF_PCLK_CTRL:
               next_prdata = {16'h0, pclk_ctrl};
            pmc_pkg::OFF_STATUS:
               next_prdata = {27'h0, osc_24m5_ready, state_code(state)};
            pmc_pkg::OFF_IRQ_STAT:
               next_prdata = {{(32-IW){1'b0}}, irq_stat};
            pmc_pkg::OFF_IRQ_MASK:
               next_prdata = {{(32-IW){1'b0}}, irq_mask};
            pmc_pkg::OFF_RETAIN:
               next_prdata = {31'h0, retain_en};
            default:
               next_prdata = 32'h0;
         endcase
      end
   end

   // Clock, oscillator and regulator controls follow the next state.
   always_comb
   begin
      logic run;
      logic asleep;
      logic off;
      run    = (next_state == pmc_pkg::ST_NORMAL) ||
               (next_state == pmc_pkg::ST_IDLE);
      asleep = (next_state == pmc_pkg::ST_SUSPEND) ||
               (next_state == pmc_pkg::ST_SNOOZE);
      off    = (next_state == pmc_pkg::ST_STOP) ||
               (next_state == pmc_pkg::ST_SHUTDOWN);
      next_pwr.core_clk_en     = next_state == pmc_pkg::ST_NORMAL; // see RULE_01, RULE_02
      next_pwr.periph_run      = run; // see RULE_01, RULE_04, RULE_05
      next_pwr.osc_24m5_en     = ~asleep & ~off; // see RULE_04, RULE_05
      next_pwr.osc_49m_en      = ~asleep & ~off &
                                 (next_system_clock.src ==
                                  pmc_pkg::CLK_SRC_49M);
      next_pwr.low_freq_osc_en = 1'b1; // see RULE_07
      next_pwr.reg_low_bias    = next_state == pmc_pkg::ST_SNOOZE; // see RULE_05
      next_pwr.power_nets_off  = off; // see RULE_10, RULE_12
      next_pwr.pin_hold        = off | (reset_any & retain_en & ~por_req); // see RULE_15
      // Peripherals run only when enabled; timers 3 and 4 may keep
      // counting from the slow oscillator while the others are stopped.
      next_periph_clk_en = next_pclk_ctrl[PERIPH_N-1:0] & {PERIPH_N{run}}; // see RULE_14
      if (asleep)
      begin
         next_periph_clk_en[pmc_pkg::BIT_TMR3] =
            next_pclk_ctrl[pmc_pkg::BIT_TMR3] &
            next_pclk_ctrl[pmc_pkg::BIT_T3_LFO]; // see RULE_07
         next_periph_clk_en[pmc_pkg::BIT_TMR4] =
            next_pclk_ctrl[pmc_pkg::BIT_TMR4] &
            next_pclk_ctrl[pmc_pkg::BIT_T4_LFO]; // see RULE_07
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state                  <= pmc_pkg::ST_NORMAL;
         power_control_first    <= '0;
         power_control_second   <= '0;
         deep_power_down_select <= 1'b0;
         system_clock.src       <= pmc_pkg::CLK_SRC_RESET; // see RULE_13
         system_clock.div       <= pmc_pkg::CLK_DIV_RESET;
         pclk_ctrl              <= '0;
         irq_stat               <= '0;
         irq_mask               <= '0;
         retain_en              <= 1'b0;
         cmp0_prev              <= 1'b0;
         prdata                 <= 32'h0;
         pwr                    <= pmc_pkg::PWR_RESET;
         periph_clk_en          <= '0;
      end
      else
      begin
         state                  <= next_state;
         power_control_first    <= next_power_control_first;
         power_control_second   <= next_power_control_second;
         deep_power_down_select <= next_deep_power_down_select;
         system_clock           <= next_system_clock;
         pclk_ctrl              <= next_pclk_ctrl;
         irq_stat               <= next_irq_stat;
         irq_mask               <= next_irq_mask;
         retain_en              <= next_retain_en;
         cmp0_prev              <= cmp0_level;
         prdata                 <= next_prdata;
         pwr                    <= next_pwr;
         periph_clk_en          <= next_periph_clk_en;
      end
   end

endmodule : pmc_top

// file: dv/pmc_monitor.sv
// Purpose: Port checker of the power mode controller.
// Assumes: One clock domain; sleep means core and fast clocks off.
// Notes:   Bound to pmc_top below.
`timescale 1ns/10ps
module pmc_monitor
#(
   parameter int PERIPH_N = 8
)
(
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic [7:0]          paddr,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic                core_irq,
   input wire logic [4:0]          wake_src,
   input wire logic                cmp0_level,
   input wire logic                reset_pin_n,
   input wire logic                por_req,
   input wire logic                other_reset_req,
   input pmc_pkg::pmc_pwr_t        pwr,
   input pmc_pkg::pmc_clk_t        system_clock,
   input wire logic [PERIPH_N-1:0] periph_clk_en
);
   logic sleep;
   logic idle;
   logic bad;
   assign sleep = !pwr.core_clk_en && !pwr.periph_run
                  && !pwr.osc_24m5_en && !pwr.power_nets_off;
   assign idle  = !pwr.core_clk_en && pwr.periph_run
                  && !pwr.power_nets_off;
   assign bad   = paddr > 8'h20 || paddr[1:0] != 2'h0;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_bad_addr;
      psel && penable && bad |-> pslverr && pready;
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("no slverr");
   property p_good_addr;
      psel && penable && !bad |-> !pslverr;
   endproperty
   a_good_addr: assert property (p_good_addr) else $error("bad slverr");
   property p_normal;
      pwr.core_clk_en |-> pwr.periph_run && !pwr.power_nets_off;
   endproperty
   a_normal: assert property (p_normal) else $error("core alone");
   property p_idle_wake;
      idle && core_irq |-> ##[1:3] pwr.core_clk_en;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle stuck");
   property p_sleep_off;
      sleep |-> !pwr.osc_49m_en && pwr.low_freq_osc_en;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("osc on");
   property p_bias;
      pwr.reg_low_bias |-> !pwr.core_clk_en && !pwr.osc_24m5_en;
   endproperty
   a_bias: assert property (p_bias) else $error("low bias awake");
   property p_timers;
      sleep |-> (periph_clk_en & ~PERIPH_N'(8'h18)) == '0;
   endproperty
   a_timers: assert property (p_timers) else $error("clock leak");
   property p_wake;
      sleep && (|wake_src || $rose(cmp0_level)) |-> ##[1:2] pwr.osc_24m5_en;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_hold;
      pwr.power_nets_off && reset_pin_n && !por_req && !other_reset_req
      |=> pwr.power_nets_off && pwr.pin_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("left off");
   property p_pin_exit;
      pwr.power_nets_off && !reset_pin_n |=> !pwr.power_nets_off;
   endproperty
   a_pin_exit: assert property (p_pin_exit) else $error("pin");
   property p_clk_reset;
      $rose(presetn) |-> system_clock == 5'h03 && periph_clk_en == '0;
   endproperty
   a_clk_reset: assert property (p_clk_reset) else $error("clk");
endmodule : pmc_monitor

bind pmc_top pmc_monitor #(.PERIPH_N(PERIPH_N)) pmc_monitor_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .core_irq(core_irq), .wake_src(wake_src), .cmp0_level(cmp0_level),
   .reset_pin_n(reset_pin_n), .por_req(por_req),
   .other_reset_req(other_reset_req), .pwr(pwr),
   .system_clock(system_clock), .periph_clk_en(periph_clk_en));

// file: dv/pmc_partner.sv
// Purpose: Wake sources, oscillator and reset logic around the block.
// Assumes: Events are driven through the pulse task.
// Notes:   The oscillator is only ready some cycles after enable.
`timescale 1ns/10ps
module pmc_partner
#(
   parameter int READY_DLY = 3
)
(
   input wire logic          pclk,
   input pmc_pkg::pmc_pwr_t  pwr,
   output logic              core_irq,
   output logic [4:0]        wake_src,
   output logic              cmp0_level,
   output logic              osc_24m5_ready,
   output logic              reset_pin_n,
   output logic              por_req,
   output logic              other_reset_req
);
   int cnt = 0;
   initial
   begin
      core_irq = 1'b0;
      wake_src = 5'h00;
      cmp0_level = 1'b0;
      osc_24m5_ready = 1'b0;
      reset_pin_n = 1'b1;
      por_req = 1'b0;
      other_reset_req = 1'b0;
   end
   // A stopped oscillator loses ready at once and must settle again.
   always @(posedge pclk)
   begin
      if (!pwr.osc_24m5_en)
      begin
         cnt <= 0;
         osc_24m5_ready <= 1'b0;
      end
      else if (cnt < READY_DLY)
         cnt <= cnt + 1;
      else
         osc_24m5_ready <= 1'b1;
   end
   task automatic pulse(input int k);
      @(posedge pclk);
      case (k)
         5: cmp0_level <= 1'b1;
         6: core_irq <= 1'b1;
         7: reset_pin_n <= 1'b0;
         8: other_reset_req <= 1'b1;
         9: por_req <= 1'b1;
         default: wake_src <= 5'(1 << k);
      endcase
      repeat (2) @(posedge pclk);
      wake_src <= 5'h00;
      cmp0_level <= 1'b0;
      core_irq <= 1'b0;
      reset_pin_n <= 1'b1;
      other_reset_req <= 1'b0;
      por_req <= 1'b0;
   endtask : pulse
endmodule : pmc_partner

// file: dv/pmc_top_test.sv
// Purpose: Self-checking bench of the power mode controller.
// Assumes: APB answers in its own time; waits are bounded.
// Notes:   Outputs are sampled at the falling edge, except APB replies, taken at the rising edge.
`timescale 1ns/10ps
module pmc_top_test;
   logic              pclk, presetn, psel, penable, pwrite;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, q;
   logic              pready, pslverr, e, irq, reset_req;
   logic              core_irq, cmp0_level, osc_24m5_ready;
   logic              reset_pin_n, por_req, other_reset_req;
   logic [4:0]        wake_src;
   logic [7:0]        periph_clk_en;
   pmc_pkg::pmc_pwr_t pwr;
   pmc_pkg::pmc_clk_t system_clock;
   int                n_fail = 0;
   int                tests_run = 0;
   pmc_top pmc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .pslverr, .prdata, .core_irq, .wake_src,
      .cmp0_level, .osc_24m5_ready, .reset_pin_n, .por_req,
      .other_reset_req, .pwr, .system_clock, .periph_clk_en, .reset_req,
      .irq);
   pmc_partner pmc_partner_i (.pclk, .pwr, .core_irq, .wake_src,
      .cmp0_level, .osc_24m5_ready, .reset_pin_n, .por_req,
      .other_reset_req);
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
         n_fail++;
      end
   endtask : chk
   task automatic hang();
      n_fail++;
      tally_and_finish();
   endtask : hang
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; n < 20 && pready !== 1'b1; n++)
         @(posedge pclk);
      if (n == 20)
         hang();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd
   task automatic wait_st(input logic [3:0] s);
      int n;
      for (n = 0; n < 40; n++)
      begin
         bus(1'b0, pmc_pkg::OFF_STATUS, 32'h0);
         if (q[3:0] === s)
            break;
      end
      if (n == 40)
         hang();
   endtask : wait_st
   task automatic t_reset();
      @(negedge pclk);
      chk(32'(system_clock), 32'h3);
      chk(32'(pwr), 32'hE8);
      chk(32'(periph_clk_en), 32'h0);
      rd(pmc_pkg::OFF_CLK_CTRL, 32'h0C);
      bus(1'b0, 8'h24, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
   endtask : t_reset
   task automatic t_idle();
      bus(1'b1, pmc_pkg::OFF_PWR_FIRST, 32'h1);
      wait_st(4'h1);
      @(negedge pclk);
      chk(32'(pwr), 32'h68);
      pmc_partner_i.pulse(6);
      wait_st(4'h0);
      rd(pmc_pkg::OFF_PWR_FIRST, 32'h0);
      rd(pmc_pkg::OFF_IRQ_STAT, 32'h1);
      bus(1'b1, pmc_pkg::OFF_IRQ_MASK, 32'h7);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, pmc_pkg::OFF_IRQ_STAT, 32'h1);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
   endtask : t_idle
   task automatic t_sleep(input int k);
      bus(1'b1, pmc_pkg::OFF_PCLK_CTRL, 32'h219);
      bus(1'b1, pmc_pkg::OFF_PWR_SECOND, 32'(1 + k % 2));
      wait_st(4'(2 + k % 2));
      @(negedge pclk);
      chk(32'(pwr), (k % 2) ? 32'h0C : 32'h08);
      chk(32'(periph_clk_en), 32'h10);
      pmc_partner_i.pulse(k);
      wait_st(4'h0);
      @(negedge pclk);
      chk(32'(periph_clk_en), 32'h19);
      rd(pmc_pkg::OFF_PWR_SECOND, 32'h0);
      rd(pmc_pkg::OFF_IRQ_STAT, 32'h2);
      bus(1'b1, pmc_pkg::OFF_IRQ_STAT, 32'h2);
   endtask : t_sleep
   task automatic t_refuse();
      bus(1'b1, pmc_pkg::OFF_CLK_CTRL, 32'h0D);
      @(negedge pclk);
      chk(32'(pwr), 32'hF8);
      bus(1'b1, pmc_pkg::OFF_PWR_SECOND, 32'h1);
      wait_st(4'h0);
      rd(pmc_pkg::OFF_PWR_SECOND, 32'h0);
      rd(pmc_pkg::OFF_IRQ_STAT, 32'h4);
      bus(1'b1, pmc_pkg::OFF_IRQ_STAT, 32'h4);
      bus(1'b1, pmc_pkg::OFF_CLK_CTRL, 32'h0C);
   endtask : t_refuse
   task automatic t_stop(input logic deep);
      bus(1'b1, pmc_pkg::OFF_RETAIN, 32'h1);
      bus(1'b1, pmc_pkg::OFF_REG_CTRL, {31'h0, deep});
      bus(1'b1, pmc_pkg::OFF_PWR_FIRST, 32'h2);
      wait_st(deep ? 4'h6 : 4'h5);
      @(negedge pclk);
      chk({pwr.power_nets_off, pwr.pin_hold}, 32'h3);
      fork
         pmc_partner_i.pulse(8);
      join_none
      @(negedge pclk);
      chk({31'h0, reset_req}, {31'h0, ~deep});
      @(negedge pclk);
      chk({31'h0, pwr.pin_hold}, 32'h1);
      if (deep)
      begin
         wait_st(4'h6);
         pmc_partner_i.pulse(7);
      end
      wait_st(4'h0);
      rd(pmc_pkg::OFF_REG_CTRL, 32'h0);
      rd(pmc_pkg::OFF_RETAIN, 32'h1);
      pmc_partner_i.pulse(9);
      rd(pmc_pkg::OFF_RETAIN, 32'h0);
   endtask : t_stop
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_idle();
      for (int k = 0; k < 6; k++)
         t_sleep(k);
      t_refuse();
      t_stop(1'b0);
      t_stop(1'b1);
      tally_and_finish();
   end
endmodule : pmc_top_test
